/* core/agr_bypass_decode.sv */
// Purpose: decode the bypass volume code into mute, reserved and attenuation
// Assumes: code is a stored register value
// Notes:   attenuation is in tenths of a dB, known only for the deep tail
`timescale 1ns/1ps
`include "agr_map.svh"
module agr_bypass_decode (
    input  wire logic [6:0]  code,
    output logic             mute,
    output logic             code_rsvd,
    output logic             atten_known,
    output logic [9:0]       atten
);

    // tail of the attenuation table, tenths of a dB
    function automatic logic [9:0] tail_atten(input logic [6:0] c);
        case (c)
            7'h61:   tail_atten = 10'h1e7;
            7'h62:   tail_atten = 10'h1ed;
            7'h63:   tail_atten = 10'h1f4;
            7'h64:   tail_atten = 10'h1f7;
            7'h65:   tail_atten = 10'h1f7;
            7'h66:   tail_atten = 10'h202;
            7'h67:   tail_atten = 10'h206;
            7'h68:   tail_atten = 10'h20b;
            7'h69:   tail_atten = 10'h20f;
            7'h6a:   tail_atten = 10'h219;
            7'h6b:   tail_atten = 10'h21e;
            7'h6c:   tail_atten = 10'h22a;
            7'h6d:   tail_atten = 10'h237;
            7'h6e:   tail_atten = 10'h247;
            7'h6f:   tail_atten = 10'h25a;
            7'h70:   tail_atten = 10'h273;
            7'h71:   tail_atten = 10'h283;
            7'h72:   tail_atten = 10'h296;
            7'h73:   tail_atten = 10'h2af;
            7'h74:   tail_atten = `AGR_ATTEN_DEEPEST;
            default: tail_atten = 10'h000;
        endcase
    endfunction : tail_atten

    // flag decode; mute wins over any attenuation figure
    assign mute        = (code == `AGR_BYP_MUTE);
    assign code_rsvd   = (code >= `AGR_BYP_RSVD_LO);
    assign atten_known = (code >= `AGR_BYP_TAB_LO) && (code <= `AGR_BYP_DEEPEST);
    assign atten       = atten_known ? tail_atten(code) : 10'h000;

endmodule : agr_bypass_decode

/* core/agr_gain_slice.sv */
// Purpose: register slice for bypass and mixer-amplifier gain control
// Assumes: one clock, plain register port, reads answered one cycle later
// Notes:   decoded bypass outputs lag the register by one cycle
//
// Local design decision: the strobed register port.
`timescale 1ns/1ps
`include "agr_map.svh"
module agr_gain_slice (
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [7:0]       reg_rdata,
    output logic             reg_rvalid,
    output logic [6:0]       bypass_vol,
    output logic             bypass_mute,
    output logic             bypass_code_rsvd,
    output logic             bypass_atten_known,
    output logic [9:0]       bypass_atten,
    output logic [5:0]       left_mix_vol,
    output logic [5:0]       right_mix_vol,
    output logic             right_mix_zero_atten
);

    // ****************************************************************
    // address decode
    // ****************************************************************
    // shared by the write and the read path
    function automatic agr_pkg::agr_sel_e sel_of(input logic [7:0] a);
        if (a == `AGR_OFF_BYPASS) begin
            sel_of = agr_pkg::AGR_SEL_BYPASS;
        end else if (a == `AGR_OFF_LMIX) begin
            sel_of = agr_pkg::AGR_SEL_LMIX;
        end else if (a == `AGR_OFF_RMIX) begin
            sel_of = agr_pkg::AGR_SEL_RMIX;
        end else if (a >= `AGR_OFF_RSVD_LO && a <= `AGR_OFF_RSVD_HI) begin
            sel_of = agr_pkg::AGR_SEL_RSVD;
        end else begin
            sel_of = agr_pkg::AGR_SEL_NONE;
        end
    endfunction : sel_of

    agr_pkg::agr_sel_e sel;
    logic              wr_bypass;
    logic [1:0]        wr_mix;
    logic [5:0]        mix_vol [2];
    logic [7:0]        mix_rd  [2];
    logic [1:0]        mix_zero;

    assign sel       = sel_of(reg_addr);
    // writes to the reserved block and unmapped space are dropped
    assign wr_bypass = reg_wr && (sel == agr_pkg::AGR_SEL_BYPASS);
    assign wr_mix[0] = reg_wr && (sel == agr_pkg::AGR_SEL_LMIX);
    assign wr_mix[1] = reg_wr && (sel == agr_pkg::AGR_SEL_RMIX);

    // ****************************************************************
    // bypass volume register
    // ****************************************************************
    logic [6:0] bypass_q;
    logic [6:0] bypass_d;

    // host keeps off reserved codes; they are stored but flagged
    assign bypass_d = wr_bypass ? reg_wdata[6:0] : bypass_q;

    // storage; d7 is never stored
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            bypass_q <= `AGR_BYP_RESET;
        end else begin
            bypass_q <= bypass_d;
        end
    end

    // ****************************************************************
    // mixer-amplifier volume registers, left then right
    // ****************************************************************
    for (genvar i = 0; i < 2; i++) begin : g_mix
        agr_mix_reg u_mix (
            .core_clk   (core_clk),
            .rst_n      (rst_n),
            .wr_hit     (wr_mix[i]),
            .wr_data    (reg_wdata),
            .vol        (mix_vol[i]),
            .rd_val     (mix_rd[i]),
            .zero_atten (mix_zero[i])
        );
    end

    // ****************************************************************
    // bypass decode and registered gain outputs
    // ****************************************************************
    logic       dec_mute;
    logic       dec_rsvd;
    logic       dec_known;
    logic [9:0] dec_atten;

    agr_bypass_decode u_byp_dec (
        .code        (bypass_q),
        .mute        (dec_mute),
        .code_rsvd   (dec_rsvd),
        .atten_known (dec_known),
        .atten       (dec_atten)
    );

    logic       mute_q;
    logic       rsvd_q;
    logic       known_q;
    logic [9:0] atten_q;

    // one pipeline stage so the analog side sees clean flop outputs
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            mute_q  <= 1'b0;
            rsvd_q  <= 1'b0;
            known_q <= 1'b0;
            atten_q <= 10'h000;
        end else begin
            mute_q  <= dec_mute;
            rsvd_q  <= dec_rsvd;
            known_q <= dec_known;
            atten_q <= dec_atten;
        end
    end

    assign bypass_vol           = bypass_q;
    assign bypass_mute          = mute_q;
    assign bypass_code_rsvd     = rsvd_q;
    assign bypass_atten_known   = known_q;
    assign bypass_atten         = atten_q;
    assign left_mix_vol         = mix_vol[0];
    assign right_mix_vol        = mix_vol[1];
    assign right_mix_zero_atten = mix_zero[1];

    // ****************************************************************
    // read path
    // ****************************************************************
    logic [7:0] rd_mux;
    logic [7:0] rdata_q;
    logic       rvalid_q;

    // reserved block and unmapped offsets read their reset value
    assign rd_mux = (sel == agr_pkg::AGR_SEL_BYPASS) ? {1'b0, bypass_q} :
                    (sel == agr_pkg::AGR_SEL_LMIX)   ? mix_rd[0] :
                    (sel == agr_pkg::AGR_SEL_RMIX)   ? mix_rd[1] :
                    `AGR_RSVD_RESET;

    // data stands only in the cycle after the strobe
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q  <= 8'h00;
            rvalid_q <= 1'b0;
        end else begin
            rdata_q  <= reg_rd ? rd_mux : 8'h00;
            rvalid_q <= reg_rd;
        end
    end

    assign reg_rdata  = rdata_q;
    assign reg_rvalid = rvalid_q;

    // ****************************************************************
    // check helpers
    // ****************************************************************
    logic [6:0] code_lag_q;

    // code that the registered gain outputs describe right now
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            code_lag_q <= `AGR_BYP_RESET;
        end else begin
            code_lag_q <= bypass_q;
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    property p_rsvd_reads_zero;
        @(posedge core_clk) disable iff (!rst_n)
        (reg_rd && reg_addr >= 8'h1a && reg_addr <= 8'h32) |=> (reg_rdata == 8'h00);
    endproperty
    a_rsvd_reads_zero: assert property (p_rsvd_reads_zero)
        else $error("reserved register read nonzero");

    property p_rsvd_write_ignored;
        @(posedge core_clk) disable iff (!rst_n)
        (reg_wr && reg_addr >= 8'h1a && reg_addr <= 8'h32)
            |=> ($stable(bypass_vol) && $stable(left_mix_vol) && $stable(right_mix_vol));
    endproperty
    a_rsvd_write_ignored: assert property (p_rsvd_write_ignored)
        else $error("reserved write changed a live register");

    property p_bypass_write_read;
        @(posedge core_clk) disable iff (!rst_n)
        (reg_wr && reg_addr == 8'h17) ##1 (reg_rd && reg_addr == 8'h17 && !reg_wr)
            |=> (reg_rdata == {1'b0, $past(reg_wdata[6:0], 2)});
    endproperty
    a_bypass_write_read: assert property (p_bypass_write_read)
        else $error("bypass volume readback wrong");

    property p_right_read;
        @(posedge core_clk) disable iff (!rst_n)
        (reg_rd && reg_addr == 8'h19) |=> (reg_rdata == {2'h0, $past(right_mix_vol)});
    endproperty
    a_right_read: assert property (p_right_read)
        else $error("right mixer readback wrong");

    property p_mute;
        @(posedge core_clk) disable iff (!rst_n)
        (bypass_vol == 7'h75) |=> (bypass_mute && !bypass_atten_known);
    endproperty
    a_mute: assert property (p_mute)
        else $error("mute code did not mute");

    property p_deepest;
        @(posedge core_clk) disable iff (!rst_n)
        (bypass_vol == 7'h74) |=> (!bypass_mute && bypass_atten == 10'd723);
    endproperty
    a_deepest: assert property (p_deepest)
        else $error("deepest step not -72.3dB");

    property p_code_rsvd;
        @(posedge core_clk) disable iff (!rst_n)
        (bypass_vol >= 7'h76) |=> bypass_code_rsvd;
    endproperty
    a_code_rsvd: assert property (p_code_rsvd)
        else $error("reserved bypass code not flagged");

    property p_right_zero;
        @(posedge core_clk) disable iff (!rst_n)
        (reg_wr && reg_addr == 8'h19 && reg_wdata[5:0] != 6'h00) |=> !right_mix_zero_atten;
    endproperty
    a_right_zero: assert property (p_right_zero)
        else $error("zero attenuation with nonzero code");

    property p_right_reset;
        @(posedge core_clk)
        $rose(rst_n) |-> (right_mix_vol == 6'h00 && right_mix_zero_atten);
    endproperty
    a_right_reset: assert property (p_right_reset)
        else $error("right mixer not at reset value");

    property p_bypass_write;
        @(posedge core_clk) disable iff (!rst_n)
        (reg_wr && reg_addr == `AGR_OFF_BYPASS) |=> (bypass_vol == $past(reg_wdata[6:0]));
    endproperty
    a_bypass_write: assert property (p_bypass_write)
        else $error("bypass volume did not take the write");

    property p_bypass_read;
        @(posedge core_clk) disable iff (!rst_n)
        (reg_rd && reg_addr == `AGR_OFF_BYPASS) |=> (reg_rdata == {1'b0, $past(bypass_vol)});
    endproperty
    a_bypass_read: assert property (p_bypass_read)
        else $error("bypass readback wrong");

    property p_left_read;
        @(posedge core_clk) disable iff (!rst_n)
        (reg_rd && reg_addr == `AGR_OFF_LMIX) |=> (reg_rdata == {2'h0, $past(left_mix_vol)});
    endproperty
    a_left_read: assert property (p_left_read)
        else $error("left mixer readback wrong");

    property p_right_write;
        @(posedge core_clk) disable iff (!rst_n)
        (reg_wr && reg_addr == `AGR_OFF_RMIX) |=> (right_mix_vol == $past(reg_wdata[5:0]));
    endproperty
    a_right_write: assert property (p_right_write)
        else $error("right mixer did not take the write");

    property p_read_answer;
        @(posedge core_clk) disable iff (!rst_n)
        reg_rd |=> reg_rvalid;
    endproperty
    a_read_answer: assert property (p_read_answer)
        else $error("read strobe got no answer");

    property p_read_idle;
        @(posedge core_clk) disable iff (!rst_n)
        !reg_rd |=> (!reg_rvalid && reg_rdata == 8'h00);
    endproperty
    a_read_idle: assert property (p_read_idle)
        else $error("read data stood without a strobe");

    property p_known_range;
        @(posedge core_clk) disable iff (!rst_n)
        (bypass_vol >= `AGR_BYP_TAB_LO && bypass_vol <= `AGR_BYP_DEEPEST)
            |=> (bypass_atten_known && !bypass_mute && !bypass_code_rsvd);
    endproperty
    a_known_range: assert property (p_known_range)
        else $error("tail code not decoded as a known step");

    property p_code_clear;
        @(posedge core_clk) disable iff (!rst_n)
        (bypass_vol < `AGR_BYP_RSVD_LO) |=> !bypass_code_rsvd;
    endproperty
    a_code_clear: assert property (p_code_clear)
        else $error("legal bypass code flagged reserved");

    property p_atten_rises;
        @(posedge core_clk) disable iff (!rst_n)
        (bypass_atten_known && $past(bypass_atten_known) && code_lag_q > $past(code_lag_q))
            |-> (bypass_atten >= $past(bypass_atten));
    endproperty
    a_atten_rises: assert property (p_atten_rises)
        else $error("attenuation fell as the code rose");

endmodule : agr_gain_slice

/* core/agr_map.svh */
// Purpose: register offsets, field layouts, reset values and codes of the gain slice
// Assumes: included by its bare name wherever these constants are needed
// Notes:   holds definitions only; the types live in agr_pkg
//
// Overview of operation
// - seven-bit read/write bypass volume in D6-D0
// - bypass code 111 0101 fully mutes path
// - code 111 0100 gives deepest -72.3dB step
// - mixer registers D7-D6 read-only, reset 00
// - right mixer volume D5-D0, reset 00 0000
// - right mixer code zero means no attenuation
// - offsets 0x1A-0x32 reserved, read-only, read zero
`ifndef AGR_MAP_SVH
`define AGR_MAP_SVH

// ****************************************************************
// register offsets
// ****************************************************************
`define AGR_ADDR_W          8
`define AGR_OFF_BYPASS      8'h17
`define AGR_OFF_LMIX        8'h18
`define AGR_OFF_RMIX        8'h19
`define AGR_OFF_RSVD_LO     8'h1a
`define AGR_OFF_RSVD_HI     8'h32

// ****************************************************************
// fields and reset values
// ****************************************************************
`define AGR_BYP_W           7
`define AGR_BYP_RESET       7'h00
`define AGR_BYP_MUTE        7'h75
`define AGR_BYP_DEEPEST     7'h74
`define AGR_BYP_RSVD_LO     7'h76
`define AGR_BYP_TAB_LO      7'h61
`define AGR_MIX_W           6
`define AGR_MIX_RESET       6'h00
`define AGR_MIX_ZERO_ATTEN  6'h00
`define AGR_RO_BITS_RESET   2'h0
`define AGR_RSVD_RESET      8'h00
`define AGR_ATTEN_W         10
`define AGR_ATTEN_DEEPEST   10'h2d3

`endif

/* core/agr_mix_reg.sv */
// Purpose: one mixer-amplifier volume register with read-only top bits
// Assumes: write strobe already decoded for this register
// Notes:   zero_atten is registered beside the field, no extra lag
`timescale 1ns/1ps
`include "agr_map.svh"
module agr_mix_reg (
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic        wr_hit,
    input  wire logic [7:0]  wr_data,
    output logic [5:0]       vol,
    output logic [7:0]       rd_val,
    output logic             zero_atten
);

    logic [5:0] vol_q;
    logic [5:0] vol_d;
    logic       zero_q;
    logic       zero_d;

    // ****************************************************************
    // field update
    // ****************************************************************
    // only d5-d0 are stored; d7-d6 of the write are dropped
    assign vol_d  = wr_hit ? wr_data[5:0] : vol_q;
    assign zero_d = (vol_d == `AGR_MIX_ZERO_ATTEN);

    // storage
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            vol_q  <= `AGR_MIX_RESET;
            zero_q <= 1'b1;
        end else begin
            vol_q  <= vol_d;
            zero_q <= zero_d;
        end
    end

    // readback, top bits pinned to their reset value
    assign rd_val     = {`AGR_RO_BITS_RESET, vol_q};
    assign vol        = vol_q;
    assign zero_atten = zero_q;

    // ****************************************************************
    // checks
    // ****************************************************************
    property p_mix_write_takes;
        @(posedge core_clk) disable iff (!rst_n)
        wr_hit |=> (vol == $past(wr_data[5:0]));
    endproperty
    a_mix_write_takes: assert property (p_mix_write_takes)
        else $error("mixer volume did not take the write");

    property p_mix_hold;
        @(posedge core_clk) disable iff (!rst_n)
        !wr_hit |=> $stable(vol);
    endproperty
    a_mix_hold: assert property (p_mix_hold)
        else $error("mixer volume changed without a write");

    property p_mix_top_ro;
        @(posedge core_clk) disable iff (!rst_n)
        (wr_hit && wr_data[7:6] != 2'h0) |=> (rd_val[7:6] == 2'h0);
    endproperty
    a_mix_top_ro: assert property (p_mix_top_ro)
        else $error("mixer read-only bits took a write");

    property p_mix_zero;
        @(posedge core_clk) disable iff (!rst_n)
        wr_hit |=> (zero_atten == ($past(wr_data[5:0]) == 6'h00));
    endproperty
    a_mix_zero: assert property (p_mix_zero)
        else $error("zero attenuation flag wrong after write");

endmodule : agr_mix_reg

/* core/agr_pkg.sv */
// Purpose: shared types of the gain slice
// Assumes: constants come from agr_map.svh
// Notes:   nothing is imported; users write agr_pkg::name
package agr_pkg;

    // ****************************************************************
    // types
    // ****************************************************************
    typedef logic [7:0] agr_byte_t;

    // decoded register target of a bus access
    typedef enum logic [2:0] {
        AGR_SEL_NONE   = 3'b000,
        AGR_SEL_BYPASS = 3'b001,
        AGR_SEL_LMIX   = 3'b010,
        AGR_SEL_RMIX   = 3'b011,
        AGR_SEL_RSVD   = 3'b100
    } agr_sel_e;

endpackage : agr_pkg

/* test/agr_tb.sv */
// Purpose: self-checking bench for the gain register slice
// Assumes: agr_map.svh on the include path; one clock, async low reset
// Notes:   accesses leave at least one idle cycle, except two back-to-back pairs
`timescale 1ns/1ps
`include "agr_map.svh"
module testbench;

    // ****************************************************************
    // design ports and bench state
    // ****************************************************************
    logic        core_clk;
    logic        rst_n;
    logic [7:0]  reg_addr;
    logic [7:0]  reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [7:0]  reg_rdata;
    logic        reg_rvalid;
    logic [6:0]  bypass_vol;
    logic        bypass_mute;
    logic        bypass_code_rsvd;
    logic        bypass_atten_known;
    logic [9:0]  bypass_atten;
    logic [5:0]  left_mix_vol;
    logic [5:0]  right_mix_vol;
    logic        right_mix_zero_atten;
    int          fails;
    int          tests_run;
    logic [6:0]  code_tab  [8];
    logic [9:0]  atten_tab [8];
    logic [6:0]  c;

    // clock toggles every half period of 10 ns
    always #5 core_clk = ~core_clk;

    agr_gain_slice DUT (
        .core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .bypass_vol(bypass_vol), .bypass_mute(bypass_mute),
        .bypass_code_rsvd(bypass_code_rsvd), .bypass_atten_known(bypass_atten_known),
        .bypass_atten(bypass_atten), .left_mix_vol(left_mix_vol),
        .right_mix_vol(right_mix_vol), .right_mix_zero_atten(right_mix_zero_atten)
    );

    // ****************************************************************
    // shared tasks
    // ****************************************************************
    // one compare; four-state equality so an unknown never matches
    task automatic chk(input string what, input logic [9:0] seen, input logic [9:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // one-cycle write strobe; returns just after the edge that takes it
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr    <= 1'b0;
        #1;
    endtask : wr

    // read, compare the answer, then see that the answer lasts one cycle
    task automatic rd(input string what, input logic [7:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd   <= 1'b0;
        #1;
        chk({what, " valid"}, 10'(reg_rvalid), 10'h001);
        chk(what, 10'(reg_rdata), 10'(exp));
        @(posedge core_clk);
        #1;
        chk({what, " after"}, 10'({reg_rvalid, reg_rdata}), 10'h000);
    endtask : rd

    // write then read with no idle cycle between the strobes
    task automatic wr_rd(input string what, input logic [7:0] a, input logic [7:0] d,
                         input logic [7:0] exp);
        @(posedge core_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr    <= 1'b0;
        reg_rd    <= 1'b1;
        @(posedge core_clk);
        reg_rd    <= 1'b0;
        #1;
        chk({what, " valid"}, 10'(reg_rvalid), 10'h001);
        chk(what, 10'(reg_rdata), 10'(exp));
    endtask : wr_rd

    // single place where the run ends
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : print_verdict

    // watchdog; the whole sequence needs well under a thousand cycles
    initial begin
        #(5000 * 10);
        fails++;
        $display("Error watchdog expired");
        print_verdict();
    end

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        core_clk  = 1'b0;
        rst_n     = 1'b0;
        reg_addr  = 8'h00;
        reg_wdata = 8'h00;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        fails     = 0;
        tests_run = 0;
        // host keeps to legal bypass codes only
        code_tab  = '{7'h00, 7'h60, 7'h61, 7'h6e, 7'h73, 7'h74, 7'h75, 7'h62};
        atten_tab = '{10'h000, 10'h000, 10'h1e7, 10'h247, 10'h2af, 10'h2d3, 10'h000, 10'h1ed};
        repeat (2) @(posedge core_clk);
        #1;
        chk("rst zero_atten", 10'(right_mix_zero_atten), 10'h001);
        chk("rst right vol", 10'(right_mix_vol), 10'h000);
        chk("rst mute", 10'(bypass_mute), 10'h000);
        @(posedge core_clk);
        rst_n <= 1'b1;
        // defaults after reset
        rd("bypass rst", `AGR_OFF_BYPASS, 8'h00);
        rd("left rst", `AGR_OFF_LMIX, 8'h00);
        rd("right rst", `AGR_OFF_RMIX, 8'h00);
        // top bits of the mixers ignore writes
        wr(`AGR_OFF_RMIX, 8'hff);
        chk("right vol", 10'(right_mix_vol), 10'h03f);
        chk("right zero", 10'(right_mix_zero_atten), 10'h000);
        rd("right ro", `AGR_OFF_RMIX, 8'h3f);
        wr(`AGR_OFF_LMIX, 8'hc5);
        chk("left vol", 10'(left_mix_vol), 10'h005);
        rd("left ro", `AGR_OFF_LMIX, 8'h05);
        // whole reserved block, both ends included, plus one unmapped place
        for (int a = `AGR_OFF_RSVD_LO; a <= `AGR_OFF_RSVD_HI; a++) begin
            wr(8'(a), 8'hff);
            rd("reserved", 8'(a), 8'h00);
        end
        wr(8'h33, 8'ha5);
        rd("unmapped", 8'h33, 8'h00);
        chk("right kept", 10'(right_mix_vol), 10'h03f);
        chk("left kept", 10'(left_mix_vol), 10'h005);
        wr(`AGR_OFF_RMIX, 8'h00);
        chk("right zero back", 10'(right_mix_zero_atten), 10'h001);
        // bypass field is seven bits wide
        wr(`AGR_OFF_BYPASS, 8'hf5);
        rd("bypass d7", `AGR_OFF_BYPASS, 8'h75);
        // decoded bypass outputs lag the stored code by one cycle
        for (int i = 0; i < 8; i++) begin
            c = code_tab[i];
            wr(`AGR_OFF_BYPASS, {1'b0, c});
            chk("bypass vol", 10'(bypass_vol), 10'(c));
            @(posedge core_clk);
            #1;
            chk("mute", 10'(bypass_mute), 10'(c == `AGR_BYP_MUTE));
            chk("code rsvd", 10'(bypass_code_rsvd), 10'(c >= `AGR_BYP_RSVD_LO));
            chk("known", 10'(bypass_atten_known), 10'(c >= 7'h61 && c <= 7'h74));
            chk("atten", bypass_atten, atten_tab[i]);
        end
        // back-to-back pairs; bypass first so its readback check lands before reset
        wr_rd("b2b bypass", `AGR_OFF_BYPASS, 8'h33, 8'h33);
        wr_rd("b2b data", `AGR_OFF_RMIX, 8'h2a, 8'h2a);
        // reset in mid-run restores every default
        @(posedge core_clk);
        rst_n <= 1'b0;
        @(posedge core_clk);
        #1;
        chk("rerst right", 10'(right_mix_vol), 10'h000);
        chk("rerst zero", 10'(right_mix_zero_atten), 10'h001);
        chk("rerst bypass", 10'(bypass_vol), 10'h000);
        @(posedge core_clk);
        rst_n <= 1'b1;
        rd("right rerst", `AGR_OFF_RMIX, 8'h00);
        print_verdict();
    end

endmodule : testbench
